// ---- hw/pkh_device.sv ----
// Peripheral end: emulated keyboard or mouse on the two-wire link
//
// Operation
// - Lines open-drain, driven only during transfers
// - Peripheral clocks link, tolerates host holding clock
// - Frame: start, LSB-first byte, odd parity, stop
// - Eleven clock pulses; host samples falling edge
// - Keyboard link works both ways for commands
// - Announce self-test pass before accepting commands
// - Read-ID command answered with identity code
// - Mouse sends identity right after self-test code
// - Held key repeats its code every period
// - Release sends break prefix then code
// - Extended keys add extend prefix
// - Host combines shift and key codes; pkh_host does not, it only reports the raw bytes
// - Send only while clock and data high
// - Clock held low by host inhibits sending
// - Indicator command acked, next byte sets lamps
// - Echo command returns echo
// - Rate command acked, next byte sets rate
// - Resend command repeats last sent byte
// - Reset command resets the peripheral
`default_nettype none
module pkh_device
  import pkh_pkg::*;
#(
  parameter int REPEAT_CYC = pkh_pkg::REPEAT_CYC,
  parameter int HALF_CYC = pkh_pkg::HALF_CYC,
  parameter logic [7:0] KBD_ID = 8'h5a, // Arbitrary identity value
  parameter logic [7:0] MOUSE_ID = 8'h3c // Arbitrary identity value
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link
  pkh_link_if.dev link,
  // Peripheral kind, caught at reset
  input wire logic is_mouse_in,
  // Key events
  input wire logic key_valid_in,
  input wire logic [7:0] key_code_in,
  input wire logic key_ext_in,
  input wire logic key_break_in,
  output logic key_ready_out,
  // Settings from the host
  output logic [pkh_pkg::LED_W-1:0] led_out,
  output logic [7:0] rate_out
);
  import pkh_pkg::*;

  localparam int CW = 16;
  localparam int RW = 27;

  // Refuse timings the counters cannot hold
  if (HALF_CYC <= 2 * SYNC_LAT || HALF_CYC >= 2 ** CW) begin
    $error("HALF_CYC out of range");
  end
  if (REPEAT_CYC < 1 || REPEAT_CYC >= 2 ** RW) begin
    $error("REPEAT_CYC out of range");
  end

  pkh_dev_state_e state;
  pkh_arg_e arg;
  logic [CW-1:0] cnt;
  logic ph;
  logic [3:0] bitn;
  logic [11:0] frame;
  logic [10:0] rx_sh;
  logic line_clk;
  logic line_dat;
  logic expire;
  logic tx_done;
  logic rx_done;
  logic rx_bad;
  logic [7:0] rx_byte;
  logic [1:0] q_len;
  logic [1:0] q_idx;
  logic q_last;
  logic [7:0] seq [3];
  logic [7:0] last_byte;
  logic load;
  logic [1:0] next_len;
  logic [7:0] next_seq [3];
  logic mouse;
  logic starting;
  logic held;
  logic [7:0] held_code;
  logic held_ext;
  logic [RW-1:0] rep_cnt;
  logic key_take;
  logic rep_fire;
  logic [7:0] my_id;
  logic clk_low;
  logic dat_low;

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling and derived events
  pkh_sync #(.W(2)) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({link.clk_line, link.dat_line}),
    .level_out({line_clk, line_dat}),
    .fall_out()
  );

  assign expire = cnt == CW'(HALF_CYC - 1);
  assign tx_done = state == D_TX && ph && expire && bitn == TX_LAST;
  assign rx_done = state == D_RX && ph && expire && bitn == RX_LAST;
  assign rx_byte = rx_sh[8:1];
  assign rx_bad = rx_sh[0] || !rx_sh[10] ||
                  pkh_odd_par(rx_byte) != rx_sh[9];
  assign q_last = q_idx + 2'h1 == q_len;
  assign my_id = mouse ? MOUSE_ID : KBD_ID;
  assign key_ready_out = state == D_IDLE && q_len == 2'h0 && !starting &&
                         !mouse;
  assign key_take = key_valid_in && key_ready_out;
  assign rep_fire = held && rep_cnt == RW'(REPEAT_CYC - 1) && key_ready_out &&
                    !key_valid_in;

  ////////////////////////////////////////////////////////////////////////////
  // Bit engine: high half then low half per bit
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= D_IDLE;
      cnt <= '0;
      ph <= 1'b0;
      bitn <= 4'h0;
    end else begin
      unique case (state)
        D_IDLE: begin
          cnt <= '0;
          ph <= 1'b0;
          bitn <= 4'h0;
          if (q_len != 2'h0 && line_clk && line_dat) begin
            state <= D_TX;
          end else if (line_clk && !line_dat && !starting) begin
            state <= D_RX;
          end
        end
        D_TX, D_RX: begin
          if (state == D_TX && !ph && !line_clk && cnt > CW'(SYNC_LAT)) begin
            state <= D_IDLE;
          end else if (expire) begin
            cnt <= '0;
            ph <= ~ph;
            if (ph) begin
              bitn <= bitn + 4'h1;
              if (bitn == (state == D_TX ? TX_LAST : RX_LAST)) begin
                state <= D_IDLE;
              end
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // Open-drain drive, released outside frames
  assign clk_low = state != D_IDLE && ph;
  assign dat_low = (state == D_TX && !frame[bitn]) ||
                   (state == D_RX && bitn == RX_LAST);
  assign link.dev_clk_o = 1'b0;
  assign link.dev_clk_oe_n = ~clk_low;
  assign link.dev_dat_o = 1'b0;
  assign link.dev_dat_oe_n = ~dat_low;

  // Outgoing frame built while idle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      frame <= {12{1'b1}};
    end else if (state == D_IDLE) begin
      frame <= {2'b11, pkh_odd_par(seq[q_idx]), seq[q_idx], 1'b0};
    end
  end

  // Incoming bits sampled at the end of the high half of bits 0 to 10
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_sh <= 11'h000;
    end else if (state == D_RX && !ph && expire && bitn <= TX_LAST) begin
      rx_sh[bitn] <= line_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply and key sequence selection
  always_comb begin
    load = 1'b0;
    next_len = q_len;
    next_seq = seq;
    if (rx_done) begin
      load = 1'b1;
      next_len = 2'h1;
      next_seq[0] = CODE_ACK;
      if (rx_bad) begin
        next_seq[0] = CMD_RESEND;
      end else if (arg == ARG_NONE) begin
        case (rx_byte)
          CODE_ECHO: next_seq[0] = CODE_ECHO;
          CMD_READ_ID: begin
            next_seq[1] = my_id;
            next_len = 2'h2;
          end
          CMD_RESEND: next_seq[0] = last_byte;
          CMD_RESET: begin
            next_seq[1] = CODE_SELF_OK;
            next_seq[2] = my_id;
            next_len = mouse ? 2'h3 : 2'h2;
          end
          default: next_seq[0] = CODE_ACK;
        endcase
      end
    end else if (starting && q_len == 2'h0) begin
      load = 1'b1;
      next_seq[0] = CODE_SELF_OK;
      next_seq[1] = my_id;
      next_len = mouse ? 2'h2 : 2'h1;
    end else if (key_take) begin
      load = 1'b1;
      if (key_break_in) begin
        next_seq[0] = key_ext_in ? CODE_EXTEND : CODE_RELEASE;
        next_seq[1] = key_ext_in ? CODE_RELEASE : key_code_in;
        next_seq[2] = key_code_in;
        next_len = key_ext_in ? 2'h3 : 2'h2;
      end else begin
        next_seq[0] = key_ext_in ? CODE_EXTEND : key_code_in;
        next_seq[1] = key_code_in;
        next_len = key_ext_in ? 2'h2 : 2'h1;
      end
    end else if (rep_fire) begin
      load = 1'b1;
      next_seq[0] = held_ext ? CODE_EXTEND : held_code;
      next_seq[1] = held_code;
      next_len = held_ext ? 2'h2 : 2'h1;
    end
  end

  // Byte queue: loaded whole, drained one frame at a time
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      q_len <= 2'h0;
      q_idx <= 2'h0;
      last_byte <= 8'h00;
      seq <= '{8'h00, 8'h00, 8'h00};
    end else if (load) begin
      q_len <= next_len;
      q_idx <= 2'h0;
      seq <= next_seq;
    end else if (tx_done) begin
      last_byte <= seq[q_idx];
      if (q_last) begin
        q_len <= 2'h0;
        q_idx <= 2'h0;
      end else begin
        q_idx <= q_idx + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Kind strap, start-up announcement and command settings
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mouse <= is_mouse_in;
      starting <= 1'b1;
      arg <= ARG_NONE;
      led_out <= LED_RST;
      rate_out <= RATE_RST;
    end else if (rx_done && !rx_bad) begin
      arg <= ARG_NONE;
      if (arg == ARG_LEDS) begin
        led_out <= rx_byte[LED_CAPS:LED_SCROLL];
      end else if (arg == ARG_RATE) begin
        rate_out <= rx_byte;
      end else if (rx_byte == CMD_LEDS) begin
        arg <= ARG_LEDS;
      end else if (rx_byte == CMD_RATE) begin
        arg <= ARG_RATE;
      end else if (rx_byte == CMD_RESET) begin
        starting <= 1'b1;
        led_out <= LED_RST;
        rate_out <= RATE_RST;
      end
    end else if (tx_done && q_last) begin
      starting <= 1'b0;
    end
  end

  // Held key tracking and repeat timer
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      held <= 1'b0;
      held_code <= 8'h00;
      held_ext <= 1'b0;
      rep_cnt <= '0;
    end else if (rx_done && !rx_bad && arg == ARG_NONE &&
                 rx_byte == CMD_RESET) begin
      held <= 1'b0;
    end else if (key_take) begin
      rep_cnt <= '0;
      if (!key_break_in) begin
        held <= 1'b1;
        held_code <= key_code_in;
        held_ext <= key_ext_in;
      end else if (key_code_in == held_code && key_ext_in == held_ext) begin
        held <= 1'b0;
      end
    end else if (rep_fire) begin
      rep_cnt <= '0;
    end else if (held && rep_cnt != RW'(REPEAT_CYC - 1)) begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- hw/pkh_pkg.sv ----
// Shared constants, types and helpers of the keyboard link
`default_nettype none
package pkh_pkg;
  // Timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 20000;
  localparam int HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;
  localparam int INHIBIT_NS = 100000;
  localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPEAT_MS = 100;
  localparam int REPEAT_CYC = REPEAT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SYNC_LAT = 4;

  // Frame layout
  localparam logic [3:0] TX_LAST = 4'ha;
  localparam logic [3:0] RX_LAST = 4'hb;

  // Indicator fields
  localparam int LED_W = 3;
  localparam int LED_SCROLL = 0;
  localparam int LED_NUM = 1;
  localparam int LED_CAPS = 2;
  localparam logic [LED_W-1:0] LED_RST = 3'h0;
  localparam logic [7:0] RATE_RST = 8'h00;

  // Codes on the link
  localparam logic [7:0] CODE_SELF_OK = 8'haa;
  localparam logic [7:0] CODE_ACK = 8'hfa;
  localparam logic [7:0] CODE_RELEASE = 8'hf0;
  localparam logic [7:0] CODE_EXTEND = 8'he0;
  localparam logic [7:0] CODE_ECHO = 8'hee;
  localparam logic [7:0] CMD_LEDS = 8'hed;
  localparam logic [7:0] CMD_READ_ID = 8'hf2;
  localparam logic [7:0] CMD_RATE = 8'hf3;
  localparam logic [7:0] CMD_RESEND = 8'hfe;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // States
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_TX = 2'b01,
    D_RX = 2'b10
  } pkh_dev_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_INH = 2'b01,
    H_SEND = 2'b10
  } pkh_host_state_e;
  typedef enum logic [1:0] {
    ARG_NONE = 2'b00,
    ARG_LEDS = 2'b01,
    ARG_RATE = 2'b10
  } pkh_arg_e;

  // Odd parity bit for a byte
  function automatic logic pkh_odd_par(input logic [7:0] b);
    return ~^b;
  endfunction
endpackage
`default_nettype wire

// ---- hw/pkh_link_if.sv ----
// Open-drain clock and data wires between the two ends
`default_nettype none
interface pkh_link_if;
  logic dev_clk_o;
  logic dev_clk_oe_n;
  logic dev_dat_o;
  logic dev_dat_oe_n;
  logic host_clk_o;
  logic host_clk_oe_n;
  logic host_dat_o;
  logic host_dat_oe_n;
  logic clk_line;
  logic dat_line;

  // Wired-AND with pull-ups: a released line reads high
  assign clk_line = (dev_clk_oe_n | dev_clk_o) & (host_clk_oe_n | host_clk_o);
  assign dat_line = (dev_dat_oe_n | dev_dat_o) & (host_dat_oe_n | host_dat_o);

  modport dev (
    input clk_line, dat_line,
    output dev_clk_o, dev_clk_oe_n, dev_dat_o, dev_dat_oe_n
  );
  modport host (
    input clk_line, dat_line,
    output host_clk_o, host_clk_oe_n, host_dat_o, host_dat_oe_n
  );
endinterface
`default_nettype wire

// ---- hw/pkh_sync.sv ----
// Two-stage synchroniser with falling-edge detect for link lines
`default_nettype none
module pkh_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Lines from the other domain
  input wire logic [W-1:0] async_in,
  // Synchronised level and falling edge
  output logic [W-1:0] level_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Idle lines read high, so reset to high
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      s1 <= {W{1'b1}};
      s2 <= {W{1'b1}};
      s3 <= {W{1'b1}};
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Only later stages feed logic
  assign level_out = s2;
  assign fall_out = s3 & ~s2;
endmodule
`default_nettype wire

// ---- hw/pkh_host.sv ----
// Host end: receives frames and sends command bytes over the link
`default_nettype none
module pkh_host
  import pkh_pkg::*;
#(
  parameter int INHIBIT_CYC = pkh_pkg::INHIBIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link
  pkh_link_if.host link,
  // Command bytes to send
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic tx_done_out,
  output logic tx_nack_out,
  // Received bytes
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_err_out
);
  import pkh_pkg::*;

  localparam int CW = 16;

  // Refuse an inhibit the counter cannot hold
  if (INHIBIT_CYC < 1 || INHIBIT_CYC >= 2 ** CW - 1) begin
    $error("INHIBIT_CYC out of range");
  end

  pkh_host_state_e state;
  logic [CW-1:0] cnt;
  logic dat_low;
  logic [3:0] fcnt;
  logic [10:0] tx_sh;
  logic [10:0] rx_sh;
  logic [10:0] rx_next;
  logic [3:0] rx_cnt;
  logic line_clk;
  logic line_dat;
  logic [1:0] falls;
  logic clk_fall;
  logic send_end;
  logic rx_end;

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling
  pkh_sync #(.W(2)) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({link.clk_line, link.dat_line}),
    .level_out({line_clk, line_dat}),
    .fall_out(falls)
  );

  assign clk_fall = falls[1];
  assign cmd_ready_out = state == H_IDLE && rx_cnt == 4'h0 && line_clk;
  // Send ends on the twelfth fall, which carries the acknowledge
  assign send_end = state == H_SEND && clk_fall && fcnt == RX_LAST;
  assign rx_end = state == H_IDLE && clk_fall && rx_cnt == TX_LAST;
  assign rx_next = {line_dat, rx_sh[10:1]};

  ////////////////////////////////////////////////////////////////////////////
  // Send sequence: inhibit, data low, release clock, shift on falls
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= H_IDLE;
      cnt <= '0;
      dat_low <= 1'b0;
      fcnt <= 4'h0;
      tx_sh <= 11'h7ff;
    end else begin
      unique case (state)
        H_IDLE: begin
          dat_low <= 1'b0;
          cnt <= '0;
          fcnt <= 4'h0;
          if (cmd_valid_in && cmd_ready_out) begin
            tx_sh <= {2'b11, pkh_odd_par(cmd_data_in), cmd_data_in};
            state <= H_INH;
          end
        end
        H_INH: begin
          cnt <= cnt + 1'b1;
          if (cnt == CW'(INHIBIT_CYC - 1)) begin
            dat_low <= 1'b1;
          end
          if (cnt == CW'(INHIBIT_CYC)) begin
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (send_end) begin
            state <= H_IDLE;
            dat_low <= 1'b0;
          end else if (clk_fall) begin
            dat_low <= ~tx_sh[fcnt];
            fcnt <= fcnt + 4'h1;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Open-drain drive; clock held low only to inhibit
  assign link.host_clk_o = 1'b0;
  assign link.host_clk_oe_n = state != H_INH;
  assign link.host_dat_o = 1'b0;
  assign link.host_dat_oe_n = ~dat_low;

  // Send completion and acknowledge check
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tx_done_out <= 1'b0;
      tx_nack_out <= 1'b0;
    end else begin
      tx_done_out <= send_end;
      tx_nack_out <= send_end && line_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, data taken on falling clock edges
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_sh <= 11'h000;
      rx_cnt <= 4'h0;
    end else if (state != H_IDLE) begin
      rx_cnt <= 4'h0;
    end else if (clk_fall) begin
      rx_sh <= rx_next;
      rx_cnt <= rx_end ? 4'h0 : rx_cnt + 4'h1;
    end
  end

  // Received byte with start, stop and parity check
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_err_out <= 1'b0;
    end else begin
      rx_valid_out <= rx_end;
      if (rx_end) begin
        rx_data_out <= rx_next[8:1];
        rx_err_out <= rx_next[0] || !rx_next[10] ||
                      pkh_odd_par(rx_next[8:1]) != rx_next[9];
      end else begin
        rx_err_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/pkh_link_checker.sv ----
// Concurrent checks on the link wires between host and peripheral
`default_nettype none
module pkh_link_checker #(
  parameter int HALF_CYC = 50,
  parameter int INHIBIT_CYC = 100
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Driver halves and resolved lines
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe_n,
  input wire logic dev_dat_o,
  input wire logic dev_dat_oe_n,
  input wire logic host_clk_o,
  input wire logic host_clk_oe_n,
  input wire logic host_dat_o,
  input wire logic host_dat_oe_n,
  input wire logic clk_line,
  input wire logic dat_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int lo_cnt;
  int inh_cnt;
  int q_cnt;
  ////////////////////////////////////////////////////////////
  // Low time of each clock driver, quiet time of the peripheral
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      lo_cnt <= 0;
      inh_cnt <= 0;
      q_cnt <= 1000;
    end else begin
      lo_cnt <= dev_clk_oe_n ? 0 : lo_cnt + 1;
      inh_cnt <= host_clk_oe_n ? 0 : inh_cnt + 1;
      q_cnt <= !dev_clk_oe_n ? 0 : (q_cnt < 1000 ? q_cnt + 1 : q_cnt);
    end
  end
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////
  // Open-drain drivers only ever pull low
  od_low_a: assert property (
    !(dev_clk_o | dev_dat_o | host_clk_o | host_dat_o))
    else $error("link driver drives high");
  dev_low_half_a: assert property (
    $rose(dev_clk_oe_n) |-> lo_cnt == HALF_CYC)
    else $error("peripheral clock low time wrong");
  dev_dat_hold_a: assert property (
    !dev_clk_oe_n && $past(!dev_clk_oe_n) |-> $stable(dev_dat_oe_n))
    else $error("peripheral data moved while clock low");
  dev_start_idle_a: assert property (
    $fell(dev_dat_oe_n) && q_cnt > 2 * HALF_CYC + 2
      |-> $past(clk_line, 6) && $past(dat_line, 6))
    else $error("peripheral started on a busy link");
  dev_inhibit_a: assert property (
    inh_cnt > HALF_CYC + 8 |-> dev_clk_oe_n && dev_dat_oe_n)
    else $error("peripheral active during inhibit");
  host_inh_len_a: assert property (
    $rose(host_clk_oe_n) |-> inh_cnt == INHIBIT_CYC + 1)
    else $error("host inhibit length wrong");
  host_dat_first_a: assert property (
    $rose(host_clk_oe_n) |-> !host_dat_oe_n && $past(!host_dat_oe_n))
    else $error("host data not low before clock release");
  host_dat_hold_a: assert property (
    clk_line && $past(clk_line) |-> $stable(host_dat_oe_n))
    else $error("host data moved while clock high");
endmodule
`default_nettype wire

// ---- verification/ps2_keyboard_host_link_tb.sv ----
// Bench joining host and peripheral ends, plus a faulty far end
`default_nettype none
module ps2_keyboard_host_link_tb;
  import pkh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 50; // Short link half period
  localparam int IC = 100; // Short inhibit
  localparam int RC = 20000; // Short repeat period
  localparam logic [7:0] K_ID = 8'h5a; // Arbitrary value
  localparam logic [7:0] M_ID = 8'h3c; // Arbitrary value
  logic clk_sys_in, nrst_in, is_mouse_in, key_valid_in, key_ext_in;
  logic key_break_in, key_ready_out, cmd_valid_in, cmd_ready_out, cf, e2s;
  logic tx_done_out, tx_nack_out, rx_valid_out, rx_err_out, v2, e2, got2;
  logic [7:0] key_code_in, rate_out, cmd_data_in, rx_data_out, d2, c, l;
  logic [2:0] led_out;
  logic [15:0] sh;
  int n_fail, total_checks, n_rx, nb, qc, o, seed, i, t, g;
  int exq[$], wq[$], cq[$];
  time rx_t, t1;
  pkh_link_if lk_i ();
  pkh_link_if lk2_i ();
  pkh_device #(.REPEAT_CYC(RC), .HALF_CYC(HC), .KBD_ID(K_ID),
    .MOUSE_ID(M_ID)) pkh_device_i (.clk_sys_in, .nrst_in, .link(lk_i),
    .is_mouse_in, .key_valid_in, .key_code_in, .key_ext_in,
    .key_break_in, .key_ready_out, .led_out, .rate_out);
  pkh_host #(.INHIBIT_CYC(IC)) pkh_host_i (.clk_sys_in, .nrst_in,
    .link(lk_i), .cmd_valid_in, .cmd_data_in, .cmd_ready_out,
    .tx_done_out, .tx_nack_out, .rx_valid_out, .rx_data_out, .rx_err_out);
  pkh_host #(.INHIBIT_CYC(IC)) pkh_host_flt_i (.clk_sys_in, .nrst_in,
    .link(lk2_i), .cmd_valid_in(1'b0), .cmd_data_in(8'h00),
    .cmd_ready_out(), .tx_done_out(), .tx_nack_out(),
    .rx_valid_out(v2), .rx_data_out(d2), .rx_err_out(e2));
  pkh_link_checker #(.HALF_CYC(HC), .INHIBIT_CYC(IC)) pkh_link_checker_i (
    .clk_sys_in, .nrst_in, .dev_clk_o(lk_i.dev_clk_o),
    .dev_clk_oe_n(lk_i.dev_clk_oe_n), .dev_dat_o(lk_i.dev_dat_o),
    .dev_dat_oe_n(lk_i.dev_dat_oe_n), .host_clk_o(lk_i.host_clk_o),
    .host_clk_oe_n(lk_i.host_clk_oe_n), .host_dat_o(lk_i.host_dat_o),
    .host_dat_oe_n(lk_i.host_dat_oe_n), .clk_line(lk_i.clk_line),
    .dat_line(lk_i.dat_line));
  ////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys_in = 0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Compare tasks and verdict
  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic s);
    cmp_byte(nm, {7'h0, e}, {7'h0, s});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Model: bytes the peripheral should send, in order
  task automatic exp_b(input logic [7:0] b);
    exq.push_back(b);
    wq.push_back(b);
  endtask
  task automatic wait_rx(input int k);
    int e;
    e = n_rx + k;
    for (t = 0; t < 40000 && n_rx < e; t++) @(negedge clk_sys_in);
    cmp_bit("rx_count", 1, n_rx >= e);
  endtask
  task automatic send_key(input logic [7:0] k, input logic x, b);
    for (t = 0; t < 9000 && key_ready_out !== 1; t++) @(negedge clk_sys_in);
    key_code_in = k;
    key_ext_in = x;
    key_break_in = b;
    key_valid_in = 1;
    @(negedge clk_sys_in);
    key_valid_in = 0;
  endtask
  task automatic send_cmd(input logic [7:0] b);
    for (t = 0; t < 9000 && cmd_ready_out !== 1; t++) @(negedge clk_sys_in);
    cmd_data_in = b;
    cmd_valid_in = 1;
    cq.push_back(b);
    @(negedge clk_sys_in);
    cmd_valid_in = 0;
    for (t = 0; t < 9000 && tx_done_out !== 1; t++) @(negedge clk_sys_in);
    cmp_bit("tx_nack", 0, tx_nack_out);
  endtask
  // Faulty far end: one frame at 160 ns per bit
  task automatic drv_frame(input logic [10:0] f);
    for (int k = 0; k < 11; k++) begin
      lk2_i.dev_dat_oe_n = f[k];
      #40;
      lk2_i.dev_clk_oe_n = 0;
      #80;
      lk2_i.dev_clk_oe_n = 1;
      #40;
    end
    lk2_i.dev_dat_oe_n = 1;
  endtask
  ////////////////////////////////////////////////////////////
  // Received bytes against the model
  always @(posedge clk_sys_in) begin
    if (nrst_in && rx_valid_out === 1) begin
      cmp_byte("rx_data", exq.pop_front(), rx_data_out);
      cmp_bit("rx_err", 0, rx_err_out);
      n_rx++;
      rx_t = $time;
    end
    if (v2 === 1) begin
      got2 = 1;
      e2s = e2;
    end
  end
  // Wire bits taken at each clock fall; a host inhibit opens a command
  always @(negedge lk_i.clk_line) begin
    if (nb == 0)
      cf = !lk_i.host_clk_oe_n;
    sh[nb] = lk_i.dat_line;
    nb++;
    if (nb == (cf ? 13 : 11)) begin
      o = cf ? 2 : 1;
      cmp_byte("wire_byte", cf ? cq.pop_front() : wq.pop_front(),
        sh[o+:8]);
      cmp_bit("wire_par", 1, ^sh[o+:9]);
      if (cf)
        cmp_bit("wire_ack", 0, sh[12]);
      else
        cmp_byte("wire_frame", 8'h02, {6'h0, sh[10], sh[0]});
      nb = 0;
    end
  end
  // No partial frame left once the clock line has stood high a while
  always @(posedge clk_sys_in) begin
    qc = (!nrst_in || lk_i.clk_line !== 1) ? 0 : qc + 1;
    if (!nrst_in)
      nb = 0;
    if (qc == HC * 2)
      cmp_bit("wire_bits", 0, nb != 0);
  end
  // Hang guard
  initial begin
    #900000;
    n_fail++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {key_valid_in, key_ext_in, key_break_in, cmd_valid_in} = 4'h0;
    {key_code_in, cmd_data_in, is_mouse_in, nb, got2} = 0;
    {lk2_i.dev_clk_o, lk2_i.dev_dat_o} = 2'h0;
    {lk2_i.dev_clk_oe_n, lk2_i.dev_dat_oe_n} = 2'h3;
    seed = 59;
    nrst_in = 0;
    repeat (12) @(negedge clk_sys_in);
    exp_b(CODE_SELF_OK);
    nrst_in = 1;
    wait_rx(1);
    c = 8'($random(seed));
    exp_b(c);
    exp_b(c);
    send_key(c, 0, 0);
    wait_rx(1);
    t1 = rx_t;
    wait_rx(1);
    g = int'((rx_t - t1) / 10);
    cmp_bit("repeat_gap", 1, g >= RC - 10 && g <= RC + 2400);
    exp_b(CODE_RELEASE);
    exp_b(c);
    send_key(c, 0, 1);
    wait_rx(2);
    for (i = 0; i < 2; i++) begin
      exp_b(CODE_EXTEND);
      if (i)
        exp_b(CODE_RELEASE);
      exp_b(c + 8'h01);
      send_key(c + 8'h01, 1, i[0]);
      wait_rx(2 + i);
    end
    $display("keys done");
    for (i = 0; i < 2; i++) begin
      l = 8'($random(seed));
      exp_b(CODE_ACK);
      send_cmd(i ? CMD_RATE : CMD_LEDS);
      wait_rx(1);
      exp_b(CODE_ACK);
      send_cmd(l);
      wait_rx(1);
      if (i)
        cmp_byte("rate", l, rate_out);
      else
        cmp_byte("led", {5'h0, l[2:0]}, {5'h0, led_out});
    end
    exp_b(CODE_ECHO);
    send_cmd(CODE_ECHO);
    wait_rx(1);
    exp_b(CODE_ACK);
    exp_b(K_ID);
    send_cmd(CMD_READ_ID);
    wait_rx(2);
    exp_b(K_ID);
    send_cmd(CMD_RESEND);
    wait_rx(1);
    exp_b(CODE_ACK);
    exp_b(CODE_SELF_OK);
    send_cmd(CMD_RESET);
    wait_rx(2);
    cmp_byte("cleared", 8'h00, rate_out | {5'h0, led_out});
    $display("commands done");
    for (i = 0; i < 4; i++) begin
      c = 8'($random(seed));
      got2 = 0;
      #3;
      drv_frame({i != 2, ~^c ^ (i == 1), c, i == 3});
      @(negedge clk_sys_in);
      cmp_bit("rx2_seen", 1, got2);
      cmp_byte("rx2_data", c, d2);
      cmp_bit("rx2_err", i != 0, e2s);
    end
    $display("fault frames done");
    nrst_in = 0;
    is_mouse_in = 1;
    repeat (12) @(negedge clk_sys_in);
    exp_b(CODE_SELF_OK);
    exp_b(M_ID);
    nrst_in = 1;
    wait_rx(2);
    cmp_bit("key_ready", 0, key_ready_out);
    repeat (200) @(negedge clk_sys_in);
    cmp_byte("left", 8'h00, 8'(exq.size() + wq.size() + cq.size()));
    $display("mouse done");
    complete_run();
  end
endmodule
`default_nettype wire
